/* File: src/qsw_pkg.sv */
/*
 * package of the quad switch status readback and fault pin block: selection codes,
 * field positions, reset defaults.
 * assumes one system clock; spi framing is already decoded into strobes by the caller.
 */
package qsw_pkg;
    // status selection codes
    localparam logic [4:0] SEL_WDOG = 5'h0d;
    localparam logic [4:0] SEL_PINS0 = 5'h06;
    localparam logic [4:0] SEL_PINS1 = 5'h0e;
    localparam logic [4:0] SEL_PINS2 = 5'h0f;
    localparam logic [4:0] SEL_RESET = 5'h00;
    // serial output field positions
    localparam int SO_SEL_LSB = 8;
    localparam int SO_FLT_LSB = 4;
    // configuration reset defaults
    localparam logic [2:0] OCLO_DEF = 3'h0;
    localparam logic OCHI_DEF = 1'h0;
    localparam logic [1:0] BLANK_DEF = 2'h0;
    localparam logic [1:0] WATCHDOG_EXPIRED_FLAG_DEF = 2'h0;
    localparam logic SLEW_DEF = 1'h0;
    localparam logic CSNS_DEF = 1'h0;
    localparam logic DIS_DEF = 1'h0;
    localparam logic [1:0] OTL_DEF = 2'h0;
    typedef enum logic [1:0] {
        QSW_IDLE = 2'b00,
        QSW_FRAME = 2'b01
    } qsw_frame_t;
endpackage : qsw_pkg

/* File: src/qsw_fault_chan.sv */
/*
 * one output channel: fault latching, output gate and fault status contribution.
 * assumes fault inputs are synchronous levels from the analog monitors.
 */
module qsw_fault_chan
    import qsw_pkg::*;
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic nrst,
    // command and faults
    input wire logic cmdOn,
    input wire logic ovtFault,
    input wire logic uvFault,
    input wire logic ocFault,
    input wire logic ovFault,
    input wire logic olFault,
    input wire logic scFault,
    // results
    output logic gateOn,
    output logic faultFlag
);
    logic latch_q, latch_d, cmdOn_q;
    logic nonLatched;

    always_comb begin
        latch_d = latch_q;
        if (cmdOn && !cmdOn_q) begin
            latch_d = 1'b0;
        end
        if (cmdOn && (ovtFault || uvFault || ocFault)) begin
            latch_d = 1'b1; // RQ15
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            latch_q <= 1'b0;
            cmdOn_q <= 1'b0;
        end else begin
            latch_q <= latch_d;
            cmdOn_q <= cmdOn;
        end
    end

    // overvoltage acts only while present; open load and short only when commanded off
    assign nonLatched = (cmdOn && ovFault) || (!cmdOn && (olFault || scFault)); // RQ14
    assign gateOn = cmdOn && !latch_q && !ovtFault && !uvFault && !ocFault && !ovFault; // RQ13
    assign faultFlag = (cmdOn && latch_q) || nonLatched; // RQ13

    latch_hold_a: assert property (@(posedge clk_sys) disable iff (!nrst) // RQ15
        latch_q && cmdOn_q && cmdOn |=> latch_q)
        else $error("latched fault cleared without off then on");
    off_fault_a: assert property (@(posedge clk_sys) disable iff (!nrst) // RQ14
        !cmdOn |-> faultFlag == (olFault || scFault))
        else $error("open load or short not reported while off");
    on_quiet_a: assert property (@(posedge clk_sys) disable iff (!nrst) // RQ14
        cmdOn && !latch_q && !ovFault |-> !faultFlag)
        else $error("fault flag raised while on without cause");
    gate_fault_a: assert property (@(posedge clk_sys) disable iff (!nrst) // RQ13
        ovtFault || uvFault || ocFault || ovFault |-> !gateOn)
        else $error("gate on during fault");
endmodule : qsw_fault_chan

/* File: src/qsw_readback_mux.sv */
/*
 * readback selection of the low four serial output bits.
 * assumes all inputs are live levels or configuration registers.
 */
module qsw_readback_mux
    import qsw_pkg::*;
(
    // selection
    input wire logic [4:0] selCode,
    // sources
    input wire logic watchdogExpired,
    input wire logic [1:0] wdTimeout,
    input wire logic [1:0] failsafeStates,
    input wire logic watchdogEnabled,
    input wire logic wakeLevel,
    input wire logic [3:0] directInputPins,
    input wire logic [1:0] overtempLatchHi,
    input wire logic [3:0] otherData,
    // result
    output logic [3:0] readbackLowBits
);
    always_comb begin
        case (selCode)
            SEL_WDOG: readbackLowBits = {1'b0, watchdogExpired, wdTimeout}; // RQ1
            SEL_PINS0: readbackLowBits = {failsafeStates, watchdogEnabled, wakeLevel}; // RQ2 RQ3 RQ4
            SEL_PINS1: readbackLowBits = directInputPins; // RQ5
            SEL_PINS2: readbackLowBits = {overtempLatchHi, 2'h0}; // RQ6
            default: readbackLowBits = otherData;
        endcase
    end
endmodule : qsw_readback_mux

/* File: src/qsw_status_top.sv */
/*
 * status readback and fault status pin of a quad high-side switch controller.
 * assumes spi frames arrive as decoded strobes synchronous to clk_sys: csFall at
 * chip select falling, frameDone with frameValid at chip select rising.
 */
// Overview of operation
// RQ1: code 01101 returns watchdog config, expired bit
// RQ2: code 00110 returns fail-safe states outputs two, zero
// RQ3: code 00110 bit one shows watchdog enabled
// RQ4: code 00110 bit zero shows wake level
// RQ5: code 01110 mirrors direct input pins
// RQ6: code 01111 returns overtemp latch settings three, two
// RQ7: reset gives protection on, lowest settings, slow
// RQ8: standalone board grounds spi pins, fail-safe select
// RQ9: without spi inputs switch outputs, fault pin low
// RQ10: overcurrent eight low, two high levels, disableable
// RQ11: watchdog timeout one of four, default otherwise
// RQ12: two sense ratios, two slew modes over spi
// RQ13: thermal, current, voltage faults force output low
// RQ14: open load and short reported only when off
// RQ15: some faults latch; off then on clears
// RQ16: serial bits echo selection code and flags
// RQ17: selection persists; invalid frame changes nothing
// RQ18: previous selection picks data, captured at chip select fall
module qsw_status_top
    import qsw_pkg::*;
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic nrst,
    // decoded spi frame
    input wire logic csFall,
    input wire logic frameDone,
    input wire logic frameValid,
    input wire logic spiActive,
    input wire logic statusSelectCommand,
    input wire logic [4:0] statusSelectCode,
    input wire logic [3:0] spiOutputOn,
    input wire logic cfgWrite,
    input wire logic [2:0] cfgOcLow,
    input wire logic cfgOcHigh,
    input wire logic [1:0] cfgBlank,
    input wire logic [1:0] cfgWdTimeout,
    input wire logic cfgSlewFast,
    input wire logic cfgSenseEnable,
    input wire logic cfgSenseHigh,
    input wire logic cfgOcDisable,
    input wire logic cfgUvDisable,
    input wire logic cfgOvDisable,
    input wire logic [1:0] cfgOtLatchHi,
    // pins and monitors
    input wire logic [3:0] directInputPins,
    input wire logic wakeLevel,
    input wire logic [1:0] failsafeSelectInput,
    input wire logic watchdogEnabled,
    input wire logic watchdogExpiredFlag,
    input wire logic [3:0] ovtFault,
    input wire logic [3:0] uvFault,
    input wire logic [3:0] ocFault,
    input wire logic [3:0] ovFault,
    input wire logic [3:0] olFault,
    input wire logic [3:0] scFault,
    // results
    output logic [15:0] serialOutWord,
    output logic [3:0] outputGate,
    output logic faultStatusPin_n,
    output logic [2:0] ocLowLevel,
    output logic ocHighLevel,
    output logic [1:0] blankingTime,
    output logic [1:0] watchdogTimeout,
    output logic slewFast,
    output logic senseEnable,
    output logic senseHigh,
    output logic ocEnable,
    output logic uvEnable,
    output logic ovEnable
);
    qsw_frame_t frame_q, frame_d;
    logic [4:0] sel_q, sel_d;
    logic [15:0] so_q, so_d;
    logic [2:0] ocLo_q, ocLo_d;
    logic ocHi_q, ocHi_d;
    logic [1:0] blank_q, blank_d;
    logic [1:0] wdt_q, wdt_d;
    logic slew_q, slew_d;
    logic senEn_q, senEn_d;
    logic senHi_q, senHi_d;
    logic ocDis_q, ocDis_d;
    logic uvDis_q, uvDis_d;
    logic ovDis_q, ovDis_d;
    logic [1:0] otl_q, otl_d;
    logic [3:0] gate_q;
    logic fsn_q;
    logic [3:0] cmdOn;
    logic [3:0] chanGate;
    logic [3:0] chanFlag;
    logic [3:0] lowBits;
    logic [3:0] flt_q;
    logic [2:0] en_q, en_d;

    // outputs on only by their own pin unless spi is in use
    assign cmdOn = spiActive ? (spiOutputOn | directInputPins) : directInputPins; // RQ9

    genvar ch;
    generate
        for (ch = 0; ch < 4; ch++) begin : gChan
            qsw_fault_chan uChan (
                .clk_sys(clk_sys),
                .nrst(nrst),
                .cmdOn(cmdOn[ch]),
                .ovtFault(ovtFault[ch]),
                .uvFault(uvFault[ch] && !uvDis_q),
                .ocFault(ocFault[ch] && !ocDis_q),
                .ovFault(ovFault[ch] && !ovDis_q),
                .olFault(olFault[ch]),
                .scFault(scFault[ch]),
                .gateOn(chanGate[ch]),
                .faultFlag(chanFlag[ch])
            );
        end
    endgenerate

    qsw_readback_mux uMux (
        .selCode(sel_q),
        .watchdogExpired(watchdogExpiredFlag),
        .wdTimeout(wdt_q),
        .failsafeStates(failsafeSelectInput),
        .watchdogEnabled(watchdogEnabled),
        .wakeLevel(wakeLevel),
        .directInputPins(directInputPins),
        .overtempLatchHi(otl_q),
        .otherData(chanFlag),
        .readbackLowBits(lowBits)
    );

    always_comb begin
        frame_d = frame_q;
        sel_d = sel_q;
        so_d = so_q;
        if (csFall) begin
            frame_d = QSW_FRAME;
            so_d = {3'h0, sel_q, chanFlag, lowBits}; // RQ16 RQ18
        end
        if (frameDone) begin
            frame_d = QSW_IDLE;
            if (frameValid && spiActive && statusSelectCommand) begin
                sel_d = statusSelectCode; // RQ17
            end
        end
    end

    always_comb begin
        ocLo_d = ocLo_q;
        ocHi_d = ocHi_q;
        blank_d = blank_q;
        wdt_d = wdt_q;
        slew_d = slew_q;
        senEn_d = senEn_q;
        senHi_d = senHi_q;
        ocDis_d = ocDis_q;
        uvDis_d = uvDis_q;
        ovDis_d = ovDis_q;
        otl_d = otl_q;
        if (frameDone && frameValid && spiActive && cfgWrite) begin
            ocLo_d = cfgOcLow; // RQ10
            ocHi_d = cfgOcHigh; // RQ10
            ocDis_d = cfgOcDisable; // RQ10
            blank_d = cfgBlank;
            wdt_d = cfgWdTimeout; // RQ11
            slew_d = cfgSlewFast; // RQ12
            senEn_d = cfgSenseEnable; // RQ12
            senHi_d = cfgSenseHigh; // RQ12
            uvDis_d = cfgUvDisable;
            ovDis_d = cfgOvDisable;
            otl_d = cfgOtLatchHi; // RQ6
        end
        // enables kept as flops so those outputs come straight from registers
        en_d = ~{ocDis_d, uvDis_d, ovDis_d}; // RQ10
    end

    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            frame_q <= QSW_IDLE;
            sel_q <= SEL_RESET;
            so_q <= 16'h0000;
            ocLo_q <= OCLO_DEF; // RQ7
            ocHi_q <= OCHI_DEF; // RQ7
            blank_q <= BLANK_DEF; // RQ7
            wdt_q <= WATCHDOG_EXPIRED_FLAG_DEF; // RQ7
            slew_q <= SLEW_DEF; // RQ7
            senEn_q <= CSNS_DEF; // RQ7
            senHi_q <= CSNS_DEF;
            ocDis_q <= DIS_DEF; // RQ7
            uvDis_q <= DIS_DEF;
            ovDis_q <= DIS_DEF;
            otl_q <= OTL_DEF;
            gate_q <= 4'h0;
            fsn_q <= 1'b1;
            flt_q <= 4'h0;
            en_q <= ~{DIS_DEF, DIS_DEF, DIS_DEF}; // RQ7
        end else begin
            frame_q <= frame_d;
            sel_q <= sel_d;
            so_q <= so_d;
            ocLo_q <= ocLo_d;
            ocHi_q <= ocHi_d;
            blank_q <= blank_d;
            wdt_q <= wdt_d;
            slew_q <= slew_d;
            senEn_q <= senEn_d;
            senHi_q <= senHi_d;
            ocDis_q <= ocDis_d;
            uvDis_q <= uvDis_d;
            ovDis_q <= ovDis_d;
            otl_q <= otl_d;
            gate_q <= chanGate; // RQ13
            fsn_q <= ~|chanFlag; // RQ9
            flt_q <= chanFlag;
            en_q <= en_d;
        end
    end

    assign serialOutWord = so_q;
    assign outputGate = gate_q;
    assign faultStatusPin_n = fsn_q;
    assign ocLowLevel = ocLo_q;
    assign ocHighLevel = ocHi_q;
    assign blankingTime = blank_q;
    assign watchdogTimeout = wdt_q;
    assign slewFast = slew_q;
    assign senseEnable = senEn_q;
    assign senseHigh = senHi_q;
    assign ocEnable = en_q[2];
    assign uvEnable = en_q[1];
    assign ovEnable = en_q[0];

    // readback and serial word
    wdog_read_a: assert property (@(posedge clk_sys) disable iff (!nrst) // RQ1
        csFall && sel_q == SEL_WDOG |=> serialOutWord[2] == $past(watchdogExpiredFlag))
        else $error("watchdog expired bit wrong");
    pins0_read_a: assert property (@(posedge clk_sys) disable iff (!nrst) // RQ2
        csFall && sel_q == SEL_PINS0 |=> serialOutWord[3:2] == $past(failsafeSelectInput))
        else $error("fail-safe states wrong");
    wden_read_a: assert property (@(posedge clk_sys) disable iff (!nrst) // RQ3
        csFall && sel_q == SEL_PINS0 |=> serialOutWord[1] == $past(watchdogEnabled))
        else $error("watchdog enable bit wrong");
    wake_read_a: assert property (@(posedge clk_sys) disable iff (!nrst) // RQ4
        csFall && sel_q == SEL_PINS0 |=> serialOutWord[0] == $past(wakeLevel))
        else $error("wake bit wrong");
    inpins_read_a: assert property (@(posedge clk_sys) disable iff (!nrst) // RQ5
        csFall && sel_q == SEL_PINS1 |=> serialOutWord[3:0] == $past(directInputPins))
        else $error("direct input mirror wrong");
    otl_read_a: assert property (@(posedge clk_sys) disable iff (!nrst) // RQ6
        csFall && sel_q == SEL_PINS2 |=> serialOutWord[3:2] == $past(otl_q))
        else $error("overtemp latch readback wrong");
    other_read_a: assert property (@(posedge clk_sys) disable iff (!nrst) // RQ18
        csFall && sel_q == SEL_RESET |=> serialOutWord[3:0] == $past(chanFlag))
        else $error("fault flag readback wrong");
    echo_sel_a: assert property (@(posedge clk_sys) disable iff (!nrst) // RQ16
        csFall |=> serialOutWord[SO_SEL_LSB +: 5] == $past(sel_q))
        else $error("selection echo wrong");
    flags_echo_a: assert property (@(posedge clk_sys) disable iff (!nrst) // RQ16
        csFall |=> serialOutWord[SO_FLT_LSB +: 4] == flt_q)
        else $error("fault flags in serial word wrong");
    so_keep_a: assert property (@(posedge clk_sys) disable iff (!nrst) // RQ18
        !csFall |=> $stable(serialOutWord))
        else $error("serial word changed without chip select fall");
    sel_keep_a: assert property (@(posedge clk_sys) disable iff (!nrst) // RQ17
        !(frameDone && frameValid && statusSelectCommand) |=> sel_q == $past(sel_q))
        else $error("selection changed without valid command");
    sel_take_a: assert property (@(posedge clk_sys) disable iff (!nrst) // RQ17
        frameDone && frameValid && spiActive && statusSelectCommand
            |=> sel_q == $past(statusSelectCode))
        else $error("selection not taken from valid command");

    // configuration, pins and reset
    fault_pin_a: assert property (@(posedge clk_sys) disable iff (!nrst) // RQ9
        nrst && |chanFlag |=> !faultStatusPin_n)
        else $error("fault pin not low on fault");
    fault_clear_a: assert property (@(posedge clk_sys) disable iff (!nrst) // RQ9
        nrst && !(|chanFlag) |=> faultStatusPin_n)
        else $error("fault pin low without fault");
    standalone_gate_a: assert property (@(posedge clk_sys) disable iff (!nrst) // RQ9
        nrst && !spiActive |=> (outputGate & ~$past(directInputPins)) == 4'h0)
        else $error("output on without its own pin");
    oc_dis_a: assert property (@(posedge clk_sys) disable iff (!nrst) // RQ10
        frameDone && frameValid && spiActive && cfgWrite |=> ocEnable == !$past(cfgOcDisable))
        else $error("overcurrent enable not taken");
    standalone_cfg_a: assert property (@(posedge clk_sys) disable iff (!nrst) // RQ11
        !spiActive |=> $stable(watchdogTimeout) && $stable(slewFast))
        else $error("config changed without spi");
    cfg_keep_a: assert property (@(posedge clk_sys) disable iff (!nrst) // RQ12
        !(frameDone && frameValid && spiActive && cfgWrite) |=> $stable(ocLowLevel)
            && $stable(blankingTime) && $stable(senseEnable) && $stable(senseHigh))
        else $error("config changed without write");
    reset_def_a: assert property (@(posedge clk_sys) // RQ7
        !nrst |=> ocLowLevel == OCLO_DEF && ocHighLevel == OCHI_DEF
            && blankingTime == BLANK_DEF && watchdogTimeout == WATCHDOG_EXPIRED_FLAG_DEF && slewFast == SLEW_DEF
            && senseEnable == CSNS_DEF && ocEnable && uvEnable && ovEnable)
        else $error("reset defaults wrong");

    // coverage of the main scenarios
    rd_wdog_c: cover property (@(posedge clk_sys) csFall && sel_q == SEL_WDOG);
    rd_pins_c: cover property (@(posedge clk_sys) csFall && sel_q == SEL_PINS1);
    fault_c: cover property (@(posedge clk_sys) !faultStatusPin_n);
    cfg_c: cover property (@(posedge clk_sys) frameDone && frameValid && cfgWrite);
    frame_c: cover property (@(posedge clk_sys) frame_q == QSW_FRAME && frameDone);
endmodule : qsw_status_top

/* File: bench/qsw_mcu_model.sv */
/*
 * mcu side of the decoded spi link: issues one frame as strobes.
 * assumes the block samples every strobe on the rising edge of clk_sys.
 */
module qsw_mcu_model (
    // clock
    input wire logic clk_sys,
    // decoded frame strobes
    output logic csFall,
    output logic frameDone,
    output logic frameValid,
    output logic statusSelectCommand,
    output logic [4:0] statusSelectCode,
    output logic cfgWrite
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        {csFall, frameDone, frameValid, statusSelectCommand, cfgWrite} = '0;
        statusSelectCode = 5'h1f;
    end

    // chip select falls, then rises carrying either a selection or a config write
    task automatic frame(input logic [4:0] code, input logic valid, input logic cfg);
        @(posedge clk_sys);
        csFall <= 1'b1;
        @(posedge clk_sys);
        csFall <= 1'b0;
        @(posedge clk_sys);
        frameDone <= 1'b1;
        frameValid <= valid;
        statusSelectCommand <= ~cfg;
        statusSelectCode <= code;
        cfgWrite <= cfg;
        @(posedge clk_sys);
        {frameDone, frameValid, statusSelectCommand, cfgWrite} <= '0;
        // released lines do not keep the last value
        statusSelectCode <= ~code;
    endtask : frame
endmodule : qsw_mcu_model

/* File: bench/test_qsw_status_top.sv */
/*
 * self-checking bench of the status readback and fault pin block.
 * assumes qsw_pkg and the design files are compiled first.
 */
module test_qsw_status_top
    import qsw_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic clk_sys = 1'b0;
    logic nrst, spiActive, cfgOcHigh, cfgSlewFast, cfgSenseEnable, cfgSenseHigh;
    logic cfgOcDisable, cfgUvDisable, cfgOvDisable, wakeLevel, watchdogEnabled;
    logic watchdogExpiredFlag, csFall, frameDone, frameValid, statusSelectCommand, cfgWrite;
    logic [4:0] statusSelectCode;
    logic [2:0] cfgOcLow, ocLowLevel;
    logic [1:0] cfgBlank, cfgWdTimeout, cfgOtLatchHi, failsafeSelectInput;
    logic [1:0] blankingTime, watchdogTimeout;
    logic [3:0] spiOutputOn, directInputPins, ovtFault, uvFault, ocFault, ovFault;
    logic [3:0] olFault, scFault, outputGate;
    logic [15:0] serialOutWord;
    logic faultStatusPin_n, ocHighLevel, slewFast, senseEnable, senseHigh;
    logic ocEnable, uvEnable, ovEnable;
    int mismatches = 0;
    int n_compared = 0;
    wire [10:0] cfgSeen = {ocLowLevel, ocHighLevel, blankingTime, watchdogTimeout, slewFast,
        senseEnable, senseHigh};
    wire [2:0] enSeen = {ocEnable, uvEnable, ovEnable};

    always #2 clk_sys = ~clk_sys;

    qsw_mcu_model mcu_u (.clk_sys, .csFall, .frameDone, .frameValid, .statusSelectCommand,
        .statusSelectCode, .cfgWrite);

    qsw_status_top dut_u (.clk_sys, .nrst, .csFall, .frameDone, .frameValid, .spiActive,
        .statusSelectCommand, .statusSelectCode, .spiOutputOn, .cfgWrite, .cfgOcLow,
        .cfgOcHigh, .cfgBlank, .cfgWdTimeout, .cfgSlewFast, .cfgSenseEnable, .cfgSenseHigh,
        .cfgOcDisable, .cfgUvDisable, .cfgOvDisable, .cfgOtLatchHi, .directInputPins,
        .wakeLevel, .failsafeSelectInput, .watchdogEnabled, .watchdogExpiredFlag, .ovtFault,
        .uvFault, .ocFault, .ovFault, .olFault, .scFault, .serialOutWord, .outputGate,
        .faultStatusPin_n, .ocLowLevel, .ocHighLevel, .blankingTime, .watchdogTimeout,
        .slewFast, .senseEnable, .senseHigh, .ocEnable, .uvEnable, .ovEnable);

    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic wt(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask : wt

    task automatic give_verdict;
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : give_verdict

    task automatic t_reset;
        check("config", cfgSeen, {OCLO_DEF, OCHI_DEF, BLANK_DEF, WATCHDOG_EXPIRED_FLAG_DEF, SLEW_DEF, CSNS_DEF,
            CSNS_DEF});
        check("enables", enSeen, 3'h7);
        check("fault pin", faultStatusPin_n, 1'h1);
        $display("test reset done");
    endtask : t_reset

    task automatic t_select;
        logic [4:0] codes [4] = '{SEL_WDOG, SEL_PINS0, SEL_PINS1, SEL_PINS2};
        logic [3:0] exps [4] = '{{2'h1, WATCHDOG_EXPIRED_FLAG_DEF}, 4'hb, 4'ha, {OTL_DEF, 2'h0}};
        @(posedge clk_sys);
        {wakeLevel, watchdogEnabled, watchdogExpiredFlag} <= 3'h7;
        failsafeSelectInput <= 2'h2;
        directInputPins <= 4'ha;
        for (int i = 0; i < 4; i++) begin
            mcu_u.frame(codes[i], 1'b1, 1'b0);
            mcu_u.frame(codes[i], 1'b1, 1'b0);
            check("echo", serialOutWord[12:8], codes[i]);
            check("flags", serialOutWord[7:4], 4'h0);
            check("low bits", serialOutWord[3:0] & ((i == 3) ? 4'hc : 4'hf), exps[i]);
        end
        $display("test select done");
    endtask : t_select

    task automatic t_config;
        @(posedge clk_sys);
        {cfgOcLow, cfgOcHigh, cfgBlank, cfgWdTimeout, cfgSlewFast, cfgSenseEnable, cfgSenseHigh,
            cfgOcDisable, cfgUvDisable, cfgOvDisable, cfgOtLatchHi} <= 16'hffff;
        spiActive <= 1'b0;
        mcu_u.frame(SEL_WDOG, 1'b1, 1'b1);
        wt(2);
        check("frozen config", cfgSeen, 11'h0);
        check("frozen enables", enSeen, 3'h7);
        @(posedge clk_sys);
        spiActive <= 1'b1;
        mcu_u.frame(SEL_WDOG, 1'b1, 1'b1);
        wt(2);
        check("config", cfgSeen, 11'h7ff);
        check("enables", enSeen, 3'h0);
        mcu_u.frame(SEL_WDOG, 1'b1, 1'b0);
        check("latch bits", serialOutWord[3:2], 2'h3);
        mcu_u.frame(SEL_PINS1, 1'b0, 1'b0);
        mcu_u.frame(SEL_PINS1, 1'b1, 1'b0);
        check("kept echo", serialOutWord[12:8], SEL_WDOG);
        check("expired", serialOutWord[3:0], 4'h7);
        $display("test config done");
    endtask : t_config

    task automatic t_gate;
        @(posedge clk_sys);
        spiActive <= 1'b0;
        failsafeSelectInput <= 2'h0;
        spiOutputOn <= 4'h2;
        directInputPins <= 4'h5;
        wt(3);
        check("standalone gates", outputGate, 4'h5);
        @(posedge clk_sys);
        spiActive <= 1'b1;
        wt(3);
        check("spi gates", outputGate, 4'h7);
        @(posedge clk_sys);
        spiActive <= 1'b0;
        spiOutputOn <= 4'h0;
        directInputPins <= 4'h1;
        wt(3);
        $display("test gate done");
    endtask : t_gate

    task automatic t_faults;
        for (int k = 0; k < 4; k++) begin
            @(posedge clk_sys);
            {ovtFault, uvFault, ocFault, ovFault} <= 16'h1 << (4 * (3 - k));
            wt(3);
            check("fault gate", outputGate[0], 1'h0);
            check("fault pin", faultStatusPin_n, 1'h0);
            mcu_u.frame(SEL_RESET, 1'b0, 1'b0);
            check("serial flags", serialOutWord[7:4], 4'h1);
            check("serial low", serialOutWord[3:0], 4'h1);
            @(posedge clk_sys);
            {ovtFault, uvFault, ocFault, ovFault} <= '0;
            wt(3);
            check("held pin", faultStatusPin_n, (k == 3) ? 1'h1 : 1'h0);
            @(posedge clk_sys);
            directInputPins <= 4'h0;
            wt(3);
            @(posedge clk_sys);
            directInputPins <= 4'h1;
            wt(3);
            check("cleared pin", faultStatusPin_n, 1'h1);
            check("cleared gate", outputGate[0], 1'h1);
        end
        for (int j = 0; j < 2; j++) begin
            @(posedge clk_sys);
            {olFault, scFault} <= 8'h1 << (4 * (1 - j));
            wt(3);
            check("on pin", faultStatusPin_n, 1'h1);
            @(posedge clk_sys);
            directInputPins <= 4'h0;
            wt(3);
            check("off pin", faultStatusPin_n, 1'h0);
            @(posedge clk_sys);
            {olFault, scFault} <= '0;
            directInputPins <= 4'h1;
            wt(3);
        end
        $display("test faults done");
    endtask : t_faults

    initial begin
        nrst = 1'b0;
        spiActive = 1'b1;
        {cfgOcLow, cfgOcHigh, cfgBlank, cfgWdTimeout, cfgSlewFast, cfgSenseEnable, cfgSenseHigh,
            cfgOcDisable, cfgUvDisable, cfgOvDisable, cfgOtLatchHi, spiOutputOn} = '0;
        {directInputPins, wakeLevel, failsafeSelectInput, watchdogEnabled} = '0;
        {watchdogExpiredFlag, ovtFault, uvFault, ocFault, ovFault, olFault, scFault} = '0;
        repeat (6) @(posedge clk_sys);
        nrst <= 1'b1;
        wt(1);
        t_reset();
        t_select();
        t_config();
        t_gate();
        // standalone run starts from defaults, so reset in mid-run
        @(posedge clk_sys);
        nrst <= 1'b0;
        wt(2);
        @(posedge clk_sys);
        nrst <= 1'b1;
        wt(1);
        t_reset();
        t_faults();
        give_verdict();
    end

    initial begin
        #20000;
        mismatches++;
        give_verdict();
    end
endmodule : test_qsw_status_top
